// ==== rtl/fifo_ecc_rst_ctrl.sv ====
// Buffer with check-bit protection, error injection and reset sequencing
//
// What this block does
// - Single and double error flags report no error, corrected, or detected.
// - A single-bit error is corrected on the output, memory left as is.
// - The double flag is the OR over all depth-cascaded memory banks; the single flag is their OR, held low while double is set.
// - Error flags need not match the word shown or any read.
// - Both error flags are driven combinationally, no output register.
// - Write-side error indications are not synchronised before the OR; one clock serves both sides.
// - Check bits span 64-bit words; padding errors may flag double.
// - Single injection on a write flips one bit; read raises single flag.
// - Double injection flips two bits; read raises double flag.
// - Both injections together give a double-bit error.
// - With checking on, reset leaves data output and error flags alone.
// - Reset clears pointers, occupancy count, pulse output registers and memories.
// - The reset input may be removed by configuration.
// - Reset puts the core into reset state at once, no clock needed.
// - Reset acts on its rising edge, detected by synchronising logic.
// - Core leaves reset three cycles after the reset input is released.
// - Underflow on read while empty, overflow on write while full.
// - Full-type flags forced to a chosen value in reset; power up 0.
// - In reset: output reset value, empty-types 1, valid and ack low.
// - Read count is 0 in reset; power-up matches reset otherwise.
// - Full-type flags fall three cycles after reset is released.
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module fifo_ecc_rst_ctrl #(
	parameter int DATA_W = 16,
	parameter int BANKS = 2,
	parameter int BANK_DEPTH = 16,
	parameter bit ECC_EN = 1'b1,
	parameter bit RESET_EN = 1'b1,
	parameter logic [63:0] DOUT_RST_VAL = 64'h0,
	localparam int DEPTH = BANKS * BANK_DEPTH,
	localparam int CW = $clog2(DEPTH) + 1
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic fifo_rst_i,
	// Write side
	input wire logic wr_en_i,
	input wire logic [DATA_W-1:0] din_i,
	input wire logic inject_single_error_i,
	input wire logic inject_double_error_i,
	output logic full_o,
	output logic almost_full_o,
	output logic threshold_full_flag_o,
	output logic wr_ack_o,
	output logic overflow_o,
	// Read side
	input wire logic rd_en_i,
	output logic [DATA_W-1:0] dout_o,
	output logic valid_o,
	output logic underflow_o,
	output logic empty_o,
	output logic almost_empty_o,
	output logic threshold_empty_flag_o,
	output logic [CW-1:0] rd_count_o,
	output logic single_error_flag_o,
	output logic double_error_flag_o,
	// Register bus
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [fifo_ecc_pkg::APB_AW-1:0] paddr_i,
	input wire logic [fifo_ecc_pkg::APB_DW-1:0] pwdata_i,
	output logic [fifo_ecc_pkg::APB_DW-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o
);
	import fifo_ecc_pkg::*;

	localparam int BANK_AW = $clog2(BANK_DEPTH);
	localparam int BW = $clog2(BANKS);
	localparam int AW = BANK_AW + BW;
	localparam logic [CW-1:0] DEPTH_CNT = CW'(DEPTH);
	localparam logic [CW-1:0] ONE_CNT = CW'(1);
	localparam logic [CW-1:0] THR_FULL_RST = CW'(DEPTH / 2);
	localparam logic [CW-1:0] THR_EMPTY_RST = CW'(1);

	// Reset sequencing
	logic fifo_rst_prev_q;
	logic [1:0] sync_cnt_q;
	logic [1:0] sync_cnt_d;
	wire rst_req = RESET_EN && fifo_rst_i;
	wire rst_edge = rst_req && !fifo_rst_prev_q;
	wire sync_busy = (sync_cnt_q != 2'h0);
	wire in_reset = rst_req || sync_busy;
	wire core_clr = rst_i || in_reset;

	always_comb begin
		if (rst_edge) begin
			sync_cnt_d = RST_SYNC_CYCLES;
		end else if (rst_req || !sync_busy) begin
			sync_cnt_d = sync_cnt_q;
		end else begin
			sync_cnt_d = sync_cnt_q - 2'h1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			fifo_rst_prev_q <= 1'b0;
			sync_cnt_q <= 2'h0;
		end else begin
			fifo_rst_prev_q <= rst_req;
			sync_cnt_q <= sync_cnt_d;
		end
	end

	// Configuration registers
	logic full_rst_val_q;
	logic [CW-1:0] thr_full_q;
	logic [CW-1:0] thr_empty_q;

	// Pointers and occupancy
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [CW-1:0] count_q;
	wire full_int = (count_q == DEPTH_CNT);
	wire empty_int = (count_q == '0);
	wire wr_ok = wr_en_i && !full_int && !in_reset;
	wire rd_ok = rd_en_i && !empty_int && !in_reset;

	always_ff @(posedge clk_sys_i) begin
		if (core_clr) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			if (wr_ok) begin
				wr_ptr_q <= wr_ptr_q + AW'(1);
			end
			if (rd_ok) begin
				rd_ptr_q <= rd_ptr_q + AW'(1);
			end
			if (wr_ok && !rd_ok) begin
				count_q <= count_q + ONE_CNT;
			end else if (rd_ok && !wr_ok) begin
				count_q <= count_q - ONE_CNT;
			end
		end
	end

	// Handshake and error pulses, one cycle after the request
	logic wr_ack_q;
	logic valid_q;
	logic overflow_q;
	logic underflow_q;

	always_ff @(posedge clk_sys_i) begin
		if (core_clr) begin
			wr_ack_q <= 1'b0;
			valid_q <= 1'b0;
			overflow_q <= 1'b0;
			underflow_q <= 1'b0;
		end else begin
			wr_ack_q <= wr_ok;
			valid_q <= rd_ok;
			overflow_q <= wr_en_i && full_int;
			underflow_q <= rd_en_i && empty_int;
		end
	end

	// Tracks which bank produced the word on the output
	logic [BW-1:0] rd_bank_q;
	logic shown_q;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rd_bank_q <= '0;
			shown_q <= 1'b0;
		end else if (in_reset && !ECC_EN) begin
			shown_q <= 1'b0;
		end else if (rd_ok) begin
			rd_bank_q <= rd_ptr_q[AW-1 -: BW];
			shown_q <= 1'b1;
		end
	end

	// Injection mask; double wins over single
	logic [ECC_CODE_W-1:0] inj_mask;
	always_comb begin
		inj_mask = '0;
		if (ECC_EN && inject_double_error_i) begin
			inj_mask[INJ_POS_A] = 1'b1;
			inj_mask[INJ_POS_B] = 1'b1;
		end else if (ECC_EN && inject_single_error_i) begin
			inj_mask[INJ_POS_A] = 1'b1;
		end
	end

	// Padding bits above the user width are stored as zero
	wire [ECC_DATA_W-1:0] din_pad = ECC_DATA_W'(din_i);
	wire [ECC_CODE_W-1:0] wr_code = ecc_encode(din_pad) ^ inj_mask;

	logic [ECC_DATA_W-1:0] bank_data [BANKS];
	logic [BANKS-1:0] bank_sbe;
	logic [BANKS-1:0] bank_dbe;

	for (genvar b = 0; b < BANKS; b++) begin : g_bank
		wire wr_sel = (wr_ptr_q[AW-1 -: BW] == BW'(b));
		wire rd_sel = (rd_ptr_q[AW-1 -: BW] == BW'(b));
		logic [ECC_CODE_W-1:0] rd_code;

		fifo_mem_bank #(
			.WIDTH(ECC_CODE_W),
			.DEPTH(BANK_DEPTH),
			.AW(BANK_AW)
		) u_mem (
			.clk_sys_i(clk_sys_i),
			.clr_i(core_clr),
			.we_i(wr_ok && wr_sel),
			.waddr_i(wr_ptr_q[BANK_AW-1:0]),
			.wdata_i(wr_code),
			.re_i((rd_ok && rd_sel) || rst_i),
			.raddr_i(rd_ptr_q[BANK_AW-1:0]),
			.rdata_o(rd_code)
		);

		// Correction acts on the read path only
		fifo_ecc_decode u_dec (
			.code_i(rd_code),
			.data_o(bank_data[b]),
			.sbe_o(bank_sbe[b]),
			.dbe_o(bank_dbe[b])
		);
	end

	// Flags of idle banks stay visible, so they are not tied to a read
	wire flags_on = ECC_EN && shown_q;
	// One clock for both sides: write-side indications need no crossing
	wire sbe_any = flags_on && (|bank_sbe);
	wire dbe_any = flags_on && (|bank_dbe);

	assign single_error_flag_o = sbe_any && !dbe_any;
	assign double_error_flag_o = dbe_any;

	wire [DATA_W-1:0] rd_word = bank_data[rd_bank_q][DATA_W-1:0];
	wire [DATA_W-1:0] dout_rst = DOUT_RST_VAL[DATA_W-1:0];
	assign dout_o = shown_q ? rd_word : dout_rst;

	// Flag outputs other than overflow and underflow, forced at once while in reset
	wire almost_full_int = (count_q >= (DEPTH_CNT - ONE_CNT));
	wire thr_full_int = (count_q >= thr_full_q);
	wire almost_empty_int = (count_q <= ONE_CNT);
	wire thr_empty_int = (count_q <= thr_empty_q);

	assign full_o = in_reset ? full_rst_val_q : full_int;
	assign almost_full_o = in_reset ? full_rst_val_q : almost_full_int;
	assign threshold_full_flag_o = in_reset ? full_rst_val_q : thr_full_int;
	assign empty_o = in_reset || empty_int;
	assign almost_empty_o = in_reset || almost_empty_int;
	assign threshold_empty_flag_o = in_reset || thr_empty_int;
	assign rd_count_o = in_reset ? '0 : count_q;
	assign wr_ack_o = wr_ack_q && !in_reset;
	assign valid_o = valid_q && !in_reset;
	assign overflow_o = overflow_q;
	assign underflow_o = underflow_q;

	// Register bus decode
	wire apb_setup = psel_i && !penable_i;
	wire apb_access = psel_i && penable_i;
	wire hit_ctrl = (paddr_i == ADDR_CTRL);
	wire hit_thresh = (paddr_i == ADDR_THRESH);
	wire hit_status = (paddr_i == ADDR_STATUS);
	wire hit_errcnt = (paddr_i == ADDR_ERRCNT);
	wire hit_any = hit_ctrl || hit_thresh || hit_status || hit_errcnt;
	wire wr_ctrl = apb_access && pwrite_i && hit_ctrl;
	wire wr_thresh = apb_access && pwrite_i && hit_thresh;
	wire wr_status = apb_access && pwrite_i && hit_status;
	wire wr_errcnt = apb_access && pwrite_i && hit_errcnt;

	assign pready_o = 1'b1;
	assign pslverr_o = apb_access && !hit_any;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			full_rst_val_q <= CTRL_FULL_RST_RST;
			thr_full_q <= THR_FULL_RST;
			thr_empty_q <= THR_EMPTY_RST;
		end else begin
			if (wr_ctrl) begin
				full_rst_val_q <= pwdata_i[CTRL_FULL_RST_BIT];
			end
			if (wr_thresh) begin
				thr_full_q <= pwdata_i[THR_FULL_LSB +: CW];
				thr_empty_q <= pwdata_i[THR_EMPTY_LSB +: CW];
			end
		end
	end

	// Sticky overflow and underflow; write one clears, a new event wins
	logic ovf_sticky_q;
	logic udf_sticky_q;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ovf_sticky_q <= 1'b0;
			udf_sticky_q <= 1'b0;
		end else begin
			if (overflow_q) begin
				ovf_sticky_q <= 1'b1;
			end else if (wr_status && pwdata_i[STAT_OVERFLOW]) begin
				ovf_sticky_q <= 1'b0;
			end
			if (underflow_q) begin
				udf_sticky_q <= 1'b1;
			end else if (wr_status && pwdata_i[STAT_UNDERFLOW]) begin
				udf_sticky_q <= 1'b0;
			end
		end
	end

	// Error counters advance on each valid word carrying a flag
	logic [ERRCNT_W-1:0] sbe_cnt_q;
	logic [ERRCNT_W-1:0] dbe_cnt_q;
	wire sbe_seen = valid_o && single_error_flag_o;
	wire dbe_seen = valid_o && double_error_flag_o;
	wire sbe_sat = &sbe_cnt_q;
	wire dbe_sat = &dbe_cnt_q;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sbe_cnt_q <= '0;
			dbe_cnt_q <= '0;
		end else if (wr_errcnt) begin
			sbe_cnt_q <= '0;
			dbe_cnt_q <= '0;
		end else begin
			if (sbe_seen && !sbe_sat) begin
				sbe_cnt_q <= sbe_cnt_q + ERRCNT_W'(1);
			end
			if (dbe_seen && !dbe_sat) begin
				dbe_cnt_q <= dbe_cnt_q + ERRCNT_W'(1);
			end
		end
	end

	// Read words
	logic [APB_DW-1:0] ctrl_word;
	logic [APB_DW-1:0] thresh_word;
	logic [APB_DW-1:0] status_word;
	logic [APB_DW-1:0] errcnt_word;

	always_comb begin
		ctrl_word = '0;
		ctrl_word[CTRL_FULL_RST_BIT] = full_rst_val_q;
		thresh_word = '0;
		thresh_word[THR_FULL_LSB +: CW] = thr_full_q;
		thresh_word[THR_EMPTY_LSB +: CW] = thr_empty_q;
		status_word = '0;
		status_word[STAT_EMPTY] = empty_o;
		status_word[STAT_FULL] = full_o;
		status_word[STAT_ALMOST_EMPTY] = almost_empty_o;
		status_word[STAT_ALMOST_FULL] = almost_full_o;
		status_word[STAT_IN_RESET] = in_reset;
		status_word[STAT_SBE] = single_error_flag_o;
		status_word[STAT_DBE] = double_error_flag_o;
		status_word[STAT_OVERFLOW] = ovf_sticky_q;
		status_word[STAT_UNDERFLOW] = udf_sticky_q;
		status_word[STAT_COUNT_LSB +: CW] = rd_count_o;
		errcnt_word = '0;
		errcnt_word[ERRCNT_SBE_LSB +: ERRCNT_W] = sbe_cnt_q;
		errcnt_word[ERRCNT_DBE_LSB +: ERRCNT_W] = dbe_cnt_q;
	end

	wire [APB_DW-1:0] rd_mux = hit_ctrl ? ctrl_word :
		hit_thresh ? thresh_word :
		hit_status ? status_word :
		hit_errcnt ? errcnt_word : '0;

	// Read data captured in the setup cycle, shown in the access cycle
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			prdata_o <= '0;
		end else if (apb_setup && !pwrite_i) begin
			prdata_o <= rd_mux;
		end
	end

endmodule : fifo_ecc_rst_ctrl

// ==== include/fifo_ecc_pkg.sv ====
// Shared constants and the check-bit encoder for the ECC buffer
package fifo_ecc_pkg;

	// Check bits are formed over a 64-bit data word
	localparam int ECC_DATA_W = 64;
	localparam int ECC_CODE_W = 72;
	localparam int ECC_SYN_W = 7;

	// Code positions flipped by error injection
	localparam int INJ_POS_A = 3;
	localparam int INJ_POS_B = 5;

	// Register bus
	localparam int APB_AW = 8;
	localparam int APB_DW = 32;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_THRESH = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_ERRCNT = 8'h0c;

	// Control fields
	localparam int CTRL_FULL_RST_BIT = 0;
	localparam logic CTRL_FULL_RST_RST = 1'b0;
	localparam int THR_FULL_LSB = 0;
	localparam int THR_EMPTY_LSB = 16;

	// Status fields
	localparam int STAT_EMPTY = 0;
	localparam int STAT_FULL = 1;
	localparam int STAT_ALMOST_EMPTY = 2;
	localparam int STAT_ALMOST_FULL = 3;
	localparam int STAT_IN_RESET = 4;
	localparam int STAT_SBE = 5;
	localparam int STAT_DBE = 6;
	localparam int STAT_OVERFLOW = 7;
	localparam int STAT_UNDERFLOW = 8;
	localparam int STAT_COUNT_LSB = 16;

	// Error counter fields
	localparam int ERRCNT_W = 16;
	localparam int ERRCNT_SBE_LSB = 0;
	localparam int ERRCNT_DBE_LSB = 16;

	// Cycles spent leaving reset after its release
	localparam logic [1:0] RST_SYNC_CYCLES = 2'h3;

	// Hamming code with overall parity in position 0
	function automatic logic [ECC_CODE_W-1:0] ecc_encode(
		input logic [ECC_DATA_W-1:0] d
	);
		logic [ECC_CODE_W-1:0] c;
		int k;
		c = '0;
		k = 0;
		for (int i = 1; i < ECC_CODE_W; i++) begin
			if ((i & (i - 1)) != 0) begin
				c[i] = d[k];
				k++;
			end
		end
		for (int p = 0; p < ECC_SYN_W; p++) begin
			for (int i = 1; i < ECC_CODE_W; i++) begin
				if (((i >> p) & 1) == 1) begin
					c[1 << p] = c[1 << p] ^ c[i];
				end
			end
		end
		c[0] = ^c;
		return c;
	endfunction : ecc_encode

endpackage : fifo_ecc_pkg

// ==== rtl/fifo_mem_bank.sv ====
// One memory bank with registered read data and bulk clear
`timescale 1ns/1ps
module fifo_mem_bank #(
	parameter int WIDTH = 72,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic clk_sys_i,
	input wire logic clr_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [WIDTH-1:0] wdata_i,
	input wire logic re_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [WIDTH-1:0] rdata_o
);
	logic [WIDTH-1:0] mem_q [DEPTH];
	// A read during clear loads the cleared word, never a stale one
	wire [WIDTH-1:0] rd_word = clr_i ? '0 : mem_q[raddr_i];

	// Read register changes only on a read, so it holds across reset
	always_ff @(posedge clk_sys_i) begin
		if (re_i) begin
			rdata_o <= rd_word;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (clr_i) begin
				mem_q[i] <= '0;
			end else if (we_i && (waddr_i == AW'(i))) begin
				mem_q[i] <= wdata_i;
			end
		end
	end
endmodule : fifo_mem_bank

// ==== rtl/fifo_ecc_decode.sv ====
// Check-bit decoder: corrects one bit, detects two
`timescale 1ns/1ps
module fifo_ecc_decode (
	input wire logic [fifo_ecc_pkg::ECC_CODE_W-1:0] code_i,
	output logic [fifo_ecc_pkg::ECC_DATA_W-1:0] data_o,
	output logic sbe_o,
	output logic dbe_o
);
	import fifo_ecc_pkg::*;

	logic [ECC_SYN_W-1:0] syn;
	logic ovp;
	logic [ECC_CODE_W-1:0] fixed;
	int k;

	always_comb begin
		syn = '0;
		k = 0;
		for (int i = 1; i < ECC_CODE_W; i++) begin
			if (code_i[i]) begin
				syn = syn ^ ECC_SYN_W'(i);
			end
		end
		ovp = ^code_i;
		fixed = code_i;
		sbe_o = 1'b0;
		dbe_o = 1'b0;
		if (ovp && (int'(syn) < ECC_CODE_W)) begin
			fixed[syn] = ~code_i[syn];
			sbe_o = 1'b1;
		end else if (ovp || (syn != '0)) begin
			dbe_o = 1'b1;
		end
		data_o = '0;
		for (int i = 1; i < ECC_CODE_W; i++) begin
			if ((i & (i - 1)) != 0) begin
				data_o[k] = fixed[i];
				k++;
			end
		end
	end
endmodule : fifo_ecc_decode

// ==== dv/fifo_ecc_props.sv ====
// Checker for the ECC buffer reset sequencing and error flags
`timescale 1ns/1ps
module fifo_ecc_props #(
	parameter int DATA_W = 16,
	parameter int BANKS = 2,
	parameter int BANK_DEPTH = 16,
	localparam int CW = $clog2(BANKS * BANK_DEPTH) + 1
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic fifo_rst_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic full_o,
	input wire logic almost_full_o,
	input wire logic threshold_full_flag_o,
	input wire logic wr_ack_o,
	input wire logic overflow_o,
	input wire logic valid_o,
	input wire logic underflow_o,
	input wire logic empty_o,
	input wire logic almost_empty_o,
	input wire logic threshold_empty_flag_o,
	input wire logic [CW-1:0] rd_count_o,
	input wire logic [DATA_W-1:0] dout_o,
	input wire logic single_error_flag_o,
	input wire logic double_error_flag_o,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [fifo_ecc_pkg::APB_AW-1:0] paddr_i,
	input wire logic [fifo_ecc_pkg::APB_DW-1:0] pwdata_i,
	input wire logic pready_o
);
	import fifo_ecc_pkg::*;
	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	logic ctrl_q;
	logic ctrl_d;
	logic ctrl_wr;
	logic in_rst;
	// Shadow of the reset sequencer and of the full-flag reset choice
	assign in_rst = fifo_rst_i | (cnt_q != 2'h0);
	assign cnt_d = fifo_rst_i ? RST_SYNC_CYCLES
		: (in_rst ? cnt_q - 2'h1 : 2'h0);
	assign ctrl_wr = psel_i & penable_i & pwrite_i & pready_o
		& (paddr_i == ADDR_CTRL);
	assign ctrl_d = ctrl_wr ? pwdata_i[CTRL_FULL_RST_BIT] : ctrl_q;
	always_ff @(posedge clk_sys_i) begin
		cnt_q <= rst_i ? 2'h0 : cnt_d;
		ctrl_q <= rst_i ? CTRL_FULL_RST_RST : ctrl_d;
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	property p_no_pulse_rst;
		in_rst |-> !wr_ack_o && !valid_o;
	endproperty
	a_no_pulse_rst: assert property (p_no_pulse_rst)
		else $error("ack or valid during buffer reset");
	property p_rst_now;
		$rose(fifo_rst_i) |-> empty_o && rd_count_o == '0;
	endproperty
	a_rst_now: assert property (p_rst_now)
		else $error("reset state not entered at once");
	property p_rst_state;
		in_rst |-> empty_o && almost_empty_o && threshold_empty_flag_o
			&& rd_count_o == '0;
	endproperty
	a_rst_state: assert property (p_rst_state)
		else $error("empty flags or count wrong in reset");
	property p_full_force;
		in_rst |-> full_o == ctrl_q && almost_full_o == ctrl_q
			&& threshold_full_flag_o == ctrl_q;
	endproperty
	a_full_force: assert property (p_full_force)
		else $error("full flags not forced to chosen value");
	property p_release;
		$fell(fifo_rst_i) && ctrl_q |-> full_o [*3] ##1 !full_o;
	endproperty
	a_release: assert property (p_release)
		else $error("full flag release timing wrong");
	property p_ovf;
		wr_en_i && full_o && !in_rst |=> overflow_o;
	endproperty
	a_ovf: assert property (p_ovf)
		else $error("overflow missing");
	property p_unf;
		rd_en_i && empty_o && !in_rst |=> underflow_o;
	endproperty
	a_unf: assert property (p_unf)
		else $error("underflow missing");
	property p_one_flag;
		single_error_flag_o |-> !double_error_flag_o;
	endproperty
	a_one_flag: assert property (p_one_flag)
		else $error("both error flags high");
	property p_ecc_hold;
		in_rst && $past(in_rst) |-> $stable(dout_o)
			&& $stable(single_error_flag_o) && $stable(double_error_flag_o);
	endproperty
	a_ecc_hold: assert property (p_ecc_hold)
		else $error("data or error flags changed in reset");
	property p_cleared;
		$fell(in_rst) |-> empty_o && rd_count_o == '0;
	endproperty
	a_cleared: assert property (p_cleared)
		else $error("buffer not cleared after reset");
endmodule : fifo_ecc_props

bind fifo_ecc_rst_ctrl fifo_ecc_props #(
	.DATA_W(DATA_W), .BANKS(BANKS), .BANK_DEPTH(BANK_DEPTH)
) fifo_ecc_props_i (
	.clk_sys_i(clk_sys_i), .rst_i(rst_i), .fifo_rst_i(fifo_rst_i),
	.wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .full_o(full_o),
	.almost_full_o(almost_full_o),
	.threshold_full_flag_o(threshold_full_flag_o),
	.wr_ack_o(wr_ack_o), .overflow_o(overflow_o), .valid_o(valid_o),
	.underflow_o(underflow_o), .empty_o(empty_o),
	.almost_empty_o(almost_empty_o),
	.threshold_empty_flag_o(threshold_empty_flag_o),
	.rd_count_o(rd_count_o), .dout_o(dout_o),
	.single_error_flag_o(single_error_flag_o),
	.double_error_flag_o(double_error_flag_o),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
	.paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o)
);

// ==== dv/fifo_user_model.sv ====
// Write and read side user logic facing the ECC buffer
`timescale 1ns/1ps
module fifo_user_model (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic push_i,
	input wire logic pop_i,
	input wire logic rude_i,
	input wire logic [15:0] data_i,
	input wire logic inj_single_i,
	input wire logic inj_double_i,
	input wire logic full_i,
	input wire logic fifo_rst_i,
	input wire logic double_error_flag_i,
	output logic wr_en_o,
	output logic [15:0] din_o,
	output logic inject_single_error_o,
	output logic inject_double_error_o,
	output logic rd_en_o
);
	logic halt_q;
	logic halt_d;
	logic dbe_q;
	logic quiet;
	// Halt reads and non-rude writes on a new double error until the buffer is reset
	assign halt_d = fifo_rst_i ? 1'b0
		: (halt_q | (double_error_flag_i & !dbe_q));
	assign quiet = fifo_rst_i | halt_q;
	// Rude mode only for scenarios that provoke an overflow
	assign wr_en_o = push_i & (rude_i | (!quiet & !full_i));
	assign rd_en_o = pop_i & !quiet;
	assign din_o = data_i;
	assign inject_single_error_o = inj_single_i & wr_en_o;
	assign inject_double_error_o = inj_double_i & wr_en_o;
	always_ff @(posedge clk_sys_i) begin
		halt_q <= rst_i ? 1'b0 : halt_d;
		dbe_q <= rst_i ? 1'b0 : double_error_flag_i;
	end
endmodule : fifo_user_model

// ==== dv/tb_top.sv ====
// Testbench for the ECC buffer: error flags, injection and reset
`timescale 1ns/1ps
module tb_top;
	import fifo_ecc_pkg::*;
	localparam int DEPTH = 32;
	logic clk_sys_i = 1'b0, rst_i = 1'b1, fifo_rst = 1'b0;
	logic push = 1'b0, pop = 1'b0, rude = 1'b0, inj_s = 1'b0, inj_d = 1'b0;
	logic [15:0] data = 16'h0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err_seen;
	logic [APB_AW-1:0] paddr = 8'h0;
	logic [APB_DW-1:0] pwdata = 32'h0;
	logic wr_en, rd_en, inj_s_w, inj_d_w, full, almost_full, thr_full;
	logic wr_ack, overflow, valid, underflow, empty, almost_empty, thr_empty;
	logic sbe, dbe, pready, pslverr;
	logic [15:0] din, dout;
	logic [5:0] count;
	logic [31:0] prdata;
	int bad_count = 0;
	int checked = 0;

	always #12.5 clk_sys_i = ~clk_sys_i;

	fifo_ecc_rst_ctrl #(.DATA_W(16), .BANKS(2), .BANK_DEPTH(16))
	fifo_ecc_rst_ctrl_i (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .fifo_rst_i(fifo_rst),
		.wr_en_i(wr_en), .din_i(din), .inject_single_error_i(inj_s_w),
		.inject_double_error_i(inj_d_w), .full_o(full),
		.almost_full_o(almost_full), .threshold_full_flag_o(thr_full),
		.wr_ack_o(wr_ack), .overflow_o(overflow), .rd_en_i(rd_en),
		.dout_o(dout), .valid_o(valid), .underflow_o(underflow),
		.empty_o(empty), .almost_empty_o(almost_empty),
		.threshold_empty_flag_o(thr_empty), .rd_count_o(count),
		.single_error_flag_o(sbe), .double_error_flag_o(dbe),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr));

	fifo_user_model fifo_user_model_i (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .push_i(push), .pop_i(pop),
		.rude_i(rude), .data_i(data), .inj_single_i(inj_s),
		.inj_double_i(inj_d), .full_i(full), .fifo_rst_i(fifo_rst),
		.double_error_flag_i(dbe), .wr_en_o(wr_en), .din_o(din),
		.inject_single_error_o(inj_s_w), .inject_double_error_o(inj_d_w),
		.rd_en_o(rd_en));

	task automatic chk(input string nm, input logic [31:0] got,
		input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk_sys_i);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys_i);
		penable <= 1'b1;
		@(posedge clk_sys_i);
		while (pready !== 1'b1) begin
			@(posedge clk_sys_i);
		end
		rd = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdchk(input string nm, input logic [7:0] a,
		input logic [31:0] m, input logic [31:0] e);
		logic [31:0] v;
		apb(1'b0, a, 32'h0, v);
		chk(nm, v & m, e);
	endtask : rdchk

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		apb(1'b1, a, d, v);
	endtask : wreg

	task automatic put(input logic [15:0] d, input logic s, input logic dd);
		@(posedge clk_sys_i);
		push <= 1'b1;
		data <= d;
		inj_s <= s;
		inj_d <= dd;
		@(posedge clk_sys_i);
		push <= 1'b0;
		inj_s <= 1'b0;
		inj_d <= 1'b0;
		#1;
		chk("wr_ack", wr_ack, 1'b1);
	endtask : put

	// Flags ef is {single, double}; m selects data and flag checks
	task automatic get(input logic [15:0] d, input logic [1:0] ef,
		input logic [1:0] m);
		@(posedge clk_sys_i);
		pop <= 1'b1;
		@(posedge clk_sys_i);
		pop <= 1'b0;
		#1;
		chk("valid", valid, 1'b1);
		if (m[0]) chk("dout", dout, d);
		if (m[1]) chk("err_flags", {sbe, dbe}, ef);
	endtask : get

	task automatic end_of_test;
		if (bad_count == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_of_test

	initial begin
		repeat (5000) @(posedge clk_sys_i);
		bad_count++;
		end_of_test();
	end

	initial begin
		repeat (6) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(posedge clk_sys_i);
		#1;
		chk("pwr_flags", {dout, empty, almost_empty, full}, 19'h6);
		rdchk("ctrl", ADDR_CTRL, '1, 32'h0);
		rdchk("thresh", ADDR_THRESH, '1, {16'h1, 16'(DEPTH / 2)});
		rdchk("status", ADDR_STATUS, 32'h003f_01ff, 32'h5);
		rdchk("unmapped", 8'h10, '1, 32'h0);
		chk("slverr", err_seen, 1'b1);
		wreg(ADDR_CTRL, 32'h1);
		for (int i = 0; i < 5; i++) begin
			put(16'h3c00 + 16'(i), i == 1 || i == 4, i == 4);
		end
		get(16'h3c00, 2'b00, 2'b11);
		get(16'h3c01, 2'b10, 2'b11);
		get(16'h3c02, 2'b00, 2'b01);
		get(16'h3c03, 2'b00, 2'b11);
		get(16'h3c04, 2'b01, 2'b10);
		rdchk("dbe_count", ADDR_ERRCNT, 32'hffff_0000, 32'h1_0000);
		wreg(ADDR_ERRCNT, 32'h0);
		rdchk("cnt_clear", ADDR_ERRCNT, '1, 32'h0);
		@(posedge clk_sys_i);
		fifo_rst <= 1'b1;
		#1;
		chk("rst_at_once", {full, empty, count, dbe}, 9'h181);
		@(posedge clk_sys_i);
		fifo_rst <= 1'b0;
		#1;
		chk("rst_flags", {full, almost_full, thr_full, empty,
			almost_empty, thr_empty, count}, 12'hfc0);
		repeat (2) @(posedge clk_sys_i);
		#1;
		chk("full_hold", full, 1'b1);
		@(posedge clk_sys_i);
		#1;
		chk("full_free", {full, dbe}, 2'b01);
		put(16'h5a5a, 1'b0, 1'b0);
		put(16'h0f0f, 1'b0, 1'b1);
		get(16'h5a5a, 2'b00, 2'b11);
		get(16'h0f0f, 2'b01, 2'b10);
		wreg(ADDR_CTRL, 32'h0);
		@(posedge clk_sys_i);
		fifo_rst <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		fifo_rst <= 1'b0;
		#1;
		chk("rst0_flags", {full, almost_full, thr_full, empty}, 4'h1);
		repeat (3) @(posedge clk_sys_i);
		rdchk("in_reset", ADDR_STATUS, 32'h10, 32'h0);
		for (int i = 0; i < DEPTH; i++) begin
			@(posedge clk_sys_i);
			push <= 1'b1;
			data <= 16'(i);
		end
		@(posedge clk_sys_i);
		rude <= 1'b1;
		@(posedge clk_sys_i);
		push <= 1'b0;
		rude <= 1'b0;
		#1;
		chk("overflow", overflow, 1'b1);
		chk("full_set", {full, almost_full, thr_full, count},
			{3'h7, 6'(DEPTH)});
		rdchk("ovf_sticky", ADDR_STATUS, 32'h80, 32'h80);
		wreg(ADDR_STATUS, 32'h80);
		rdchk("ovf_clear", ADDR_STATUS, 32'h80, 32'h0);
		@(posedge clk_sys_i);
		pop <= 1'b1;
		for (int i = 0; i <= DEPTH; i++) begin
			@(posedge clk_sys_i);
			if (i == DEPTH) pop <= 1'b0;
			#1;
			if (i < DEPTH) chk("drain", {valid, dout}, {1'b1, 16'(i)});
			else chk("underflow", {underflow, empty}, 2'b11);
		end
		end_of_test();
	end
endmodule : tb_top
